// ### hdl/hv_cfg_pkg.sv
// constants for the second high-voltage configuration register logic
package hv_cfg_pkg;
   localparam int CFG_W = 8;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam int TMON_BIT = 6;
   localparam int VSHORT_BIT = 5;
   localparam int READBACK_BIT = 4;
   localparam int REENABLE_BIT = 3;
   localparam int PASSIVE_BIT = 2;
   localparam int WTO_DIS_BIT = 1;
   localparam int PULLUP_BIT = 0;
   localparam logic [7:0] REENABLE_MASK = 8'h08;
   // driver and short-flag vector order
   localparam int PIN_BUS = 0;
   localparam int PIN_AUX = 1;
   localparam int PIN_WAKE = 2;
   localparam int NPINS = 3;
   // edge flag vector order
   localparam int EDGE_WAKE = 0;
   localparam int EDGE_AUX = 1;
   // timing
   localparam longint CLK_PERIOD_NS = 8;
   localparam longint SHORT_BUS_NS = 20000;
   localparam longint SHORT_WAKE_NS = 400000;
   localparam longint WAKE_TIMEOUT_MS = 1300;
   localparam int SHORT_CNT_W = 16;
   localparam int TIMEOUT_CNT_W = 28;
   // least times round up
   localparam int unsigned SHORT_BUS_CYC =
      32'((SHORT_BUS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam int unsigned SHORT_WAKE_CYC =
      32'((SHORT_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   // longest time rounds down
   localparam int unsigned WAKE_TIMEOUT_CYC =
      32'((WAKE_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS);
endpackage

// ### hdl/short_filter.sv
// persistence filter: one event pulse when a short lasts LIMIT cycles
`timescale 1ns/10ps
`default_nettype none
module short_filter #(
   parameter int unsigned LIMIT = 2
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_level,
   output logic o_event
);
   import hv_cfg_pkg::*;
   typedef struct packed {
      logic [SHORT_CNT_W-1:0] cnt;
      logic fired;
      logic evt;
   } filt_t;
   filt_t q;
   filt_t next_q;

   always_comb begin
      next_q = q;
      next_q.evt = 1'b0;
      if (!i_level) begin
         // a glitch shorter than the limit leaves no trace
         next_q.cnt = '0;
         next_q.fired = 1'b0;
      end else if (!q.fired) begin
         if (q.cnt == SHORT_CNT_W'(LIMIT - 1)) begin
            next_q.evt = 1'b1;
            next_q.fired = 1'b1;
         end else begin
            next_q.cnt = q.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_event = q.evt;
endmodule
`default_nettype wire

// ### hdl/pin_sync_edge.sv
// two-stage synchroniser with registered level and edge pulse
`timescale 1ns/10ps
`default_nettype none
module pin_sync_edge (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_pin,
   output logic o_level,
   output logic o_edge
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic edge_p;
   } sync_t;
   sync_t q;
   sync_t next_q;

   always_comb begin
      next_q = q;
      next_q.s1 = i_pin;
      next_q.s2 = q.s1;
      next_q.s3 = q.s2;
      // only synchronised stages feed the detector
      next_q.edge_p = q.s2 ^ q.s3;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign o_level = q.s3;
   assign o_edge = q.edge_p;
endmodule
`default_nettype wire

// ### hdl/hv_pin_config_control.sv
// control logic behind the second high-voltage configuration register
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - bit 6 enables the temperature monitor and routes it to the converter
// - bit 5 shorts the voltage channel input for converter noise self-test
// - bit 4 enables wake and aux edge detection; each edge raises the interrupt
// - with bit 4 set, wake and aux levels read back live in monitor
// - shorts count only after 20 us on bus or aux, 400 us on wake
// - writing one to bit 3 re-enables drivers shut off by a short
// - writing one to bit 3 re-enables wake and aux after thermal shutdown
// - pending short interrupt clears only on a one written to bit 3
// - bit 3 clears itself and always reads zero
// - passive mode: bus short flags and interrupts, driver stays enabled
// - active mode: bus short flags, interrupts and disables the driver
// - a driver disabled by protection returns only on the bit 3 write
// - bit 1 clear: wake pin drops 1.3 s after assertion; set disables timeout
// - bit 0 connects the wake open-circuit diagnostic pull-up
// - wake assert bit drives wake high; cleared selects the pull-down
// - the high-voltage interrupt reaches the processor only when enabled
// - register resets to zero, accessed only through the indirect data path
module hv_pin_config_control #(
   parameter int unsigned P_WAKE_SHORT_CYC = hv_cfg_pkg::SHORT_WAKE_CYC,
   parameter int unsigned P_WAKE_TIMEOUT_CYC = hv_cfg_pkg::WAKE_TIMEOUT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst,
   // indirect data path write strobe and data
   input wire logic i_cfg_wr,
   input wire logic [hv_cfg_pkg::CFG_W-1:0] i_cfg_wdata,
   output logic [hv_cfg_pkg::CFG_W-1:0] o_cfg_rdata,
   // status register read strobe, clears edge flags
   input wire logic i_status_rd,
   // wake assert bit of the first configuration register
   input wire logic i_wake_assert,
   // interrupt enable bit of the interrupt enable register
   input wire logic i_irq_en,
   // raw short-current and thermal indications from the analogue side
   input wire logic i_bus_short,
   input wire logic i_aux_short,
   input wire logic i_wake_short,
   input wire logic i_thermal_evt,
   // pins
   input wire logic i_wake_pin,
   output logic o_wake_pin,
   output logic o_wake_pin_oe,
   input wire logic i_aux_pin,
   // analogue controls
   output logic o_tmon_en,
   output logic o_vshort_en,
   output logic o_wake_pullup_en,
   output logic o_wake_pulldown_en,
   output logic o_bus_drv_en,
   output logic o_aux_drv_en,
   output logic o_wake_drv_en,
   // monitor and status bits
   output logic o_mon_wake,
   output logic o_mon_aux,
   output logic [hv_cfg_pkg::NPINS-1:0] o_short_flags,
   output logic [1:0] o_edge_flags,
   output logic o_hv_irq
);
   import hv_cfg_pkg::*;

   typedef struct packed {
      logic [CFG_W-1:0] cfg;
      logic [NPINS-1:0] drv_on;
      logic [NPINS-1:0] short_pend;
      logic [1:0] edge_pend;
      logic [TIMEOUT_CNT_W-1:0] wake_cnt;
      logic wake_to;
      logic wake_oe;
      logic pull_dn;
      logic mon_wake;
      logic mon_aux;
      logic irq;
   } ctrl_t;

   ctrl_t q;
   ctrl_t next_q;
   logic [NPINS-1:0] short_evt;
   logic wake_lvl;
   logic wake_edge;
   logic aux_lvl;
   logic aux_edge;
   logic reenable;
   logic passive;
   logic [1:0] edge_evt;

   // hardware set wins over a clear in the same cycle
   function automatic logic [NPINS-1:0] pend_next(
      input logic [NPINS-1:0] old,
      input logic [NPINS-1:0] set,
      input logic [NPINS-1:0] clr
   );
      pend_next = set | (old & ~clr);
   endfunction

   short_filter #(
      .LIMIT(SHORT_BUS_CYC)
   ) u_bus_filt (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(i_bus_short),
      .o_event(short_evt[PIN_BUS])
   );

   short_filter #(
      .LIMIT(SHORT_BUS_CYC)
   ) u_aux_filt (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(i_aux_short),
      .o_event(short_evt[PIN_AUX])
   );

   short_filter #(
      .LIMIT(P_WAKE_SHORT_CYC)
   ) u_wake_filt (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_level(i_wake_short),
      .o_event(short_evt[PIN_WAKE])
   );

   pin_sync_edge u_wake_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_wake_pin),
      .o_level(wake_lvl),
      .o_edge(wake_edge)
   );

   pin_sync_edge u_aux_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_pin(i_aux_pin),
      .o_level(aux_lvl),
      .o_edge(aux_edge)
   );

   always_comb begin
      next_q = q;
      reenable = i_cfg_wr & i_cfg_wdata[REENABLE_BIT];
      passive = q.cfg[PASSIVE_BIT];
      edge_evt = '0;

      // the re-enable bit acts on the write and is never stored
      if (i_cfg_wr) begin
         next_q.cfg = i_cfg_wdata & ~REENABLE_MASK;
      end

      // re-enable first, so a fresh event in the same cycle still wins
      if (reenable) begin
         next_q.drv_on = '1;
      end
      if (short_evt[PIN_BUS] && !passive) begin
         next_q.drv_on[PIN_BUS] = 1'b0;
      end
      if (short_evt[PIN_AUX] && !passive) begin
         next_q.drv_on[PIN_AUX] = 1'b0;
      end
      if (short_evt[PIN_WAKE]) begin
         next_q.drv_on[PIN_WAKE] = 1'b0;
      end
      if (i_thermal_evt) begin
         next_q.drv_on[PIN_AUX] = 1'b0;
         next_q.drv_on[PIN_WAKE] = 1'b0;
      end

      // short flags clear only on the re-enable write
      next_q.short_pend = pend_next(q.short_pend, short_evt, {NPINS{reenable}});

      // edges count only while readback is enabled
      if (q.cfg[READBACK_BIT]) begin
         edge_evt[EDGE_WAKE] = wake_edge;
         edge_evt[EDGE_AUX] = aux_edge;
      end
      next_q.edge_pend = 2'(pend_next({1'b0, q.edge_pend}, {1'b0, edge_evt},
         {1'b0, {2{i_status_rd}}}));

      next_q.irq = i_irq_en & (|next_q.short_pend | |next_q.edge_pend);

      next_q.mon_wake = q.cfg[READBACK_BIT] & wake_lvl;
      next_q.mon_aux = q.cfg[READBACK_BIT] & aux_lvl;

      // wake timeout counter restarts on each new assertion
      if (!i_wake_assert || q.cfg[WTO_DIS_BIT]) begin
         next_q.wake_cnt = '0;
         next_q.wake_to = 1'b0;
      end else if (!q.wake_to) begin
         if (q.wake_cnt == TIMEOUT_CNT_W'(P_WAKE_TIMEOUT_CYC - 1)) begin
            next_q.wake_to = 1'b1;
         end else begin
            next_q.wake_cnt = q.wake_cnt + 1'b1;
         end
      end

      next_q.wake_oe = i_wake_assert & ~next_q.wake_to & next_q.drv_on[PIN_WAKE];
      next_q.pull_dn = ~i_wake_assert;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         q.cfg <= CFG_RESET;
         q.drv_on <= '1;
         q.short_pend <= '0;
         q.edge_pend <= '0;
         q.wake_cnt <= '0;
         q.wake_to <= 1'b0;
         q.wake_oe <= 1'b0;
         q.pull_dn <= 1'b1;
         q.mon_wake <= 1'b0;
         q.mon_aux <= 1'b0;
         q.irq <= 1'b0;
      end else begin
         q <= next_q;
      end
   end

   assign o_cfg_rdata = q.cfg;
   assign o_tmon_en = q.cfg[TMON_BIT];
   assign o_vshort_en = q.cfg[VSHORT_BIT];
   assign o_wake_pullup_en = q.cfg[PULLUP_BIT];
   assign o_wake_pulldown_en = q.pull_dn;
   assign o_wake_pin = q.wake_oe;
   assign o_wake_pin_oe = q.wake_oe;
   assign o_bus_drv_en = q.drv_on[PIN_BUS];
   assign o_aux_drv_en = q.drv_on[PIN_AUX];
   assign o_wake_drv_en = q.drv_on[PIN_WAKE];
   assign o_mon_wake = q.mon_wake;
   assign o_mon_aux = q.mon_aux;
   assign o_short_flags = q.short_pend;
   assign o_edge_flags = q.edge_pend;
   assign o_hv_irq = q.irq;
endmodule
`default_nettype wire

// ### tb/hv_pin_config_control_monitor.sv
// assertion checker for the configuration control block ports
`timescale 1ns/10ps
`default_nettype none
module hv_pin_config_control_monitor
   import hv_cfg_pkg::*;
#(
   parameter int unsigned P_WAKE_TIMEOUT_CYC = 20
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_cfg_wr,
   input wire logic [CFG_W-1:0] i_cfg_wdata,
   input wire logic i_wake_assert,
   input wire logic i_irq_en,
   input wire logic i_bus_short,
   input wire logic i_aux_short,
   input wire logic i_wake_short,
   input wire logic i_thermal_evt,
   input wire logic [CFG_W-1:0] o_cfg_rdata,
   input wire logic o_tmon_en,
   input wire logic o_vshort_en,
   input wire logic o_wake_pullup_en,
   input wire logic o_wake_pulldown_en,
   input wire logic o_bus_drv_en,
   input wire logic o_aux_drv_en,
   input wire logic o_wake_drv_en,
   input wire logic o_wake_pin_oe,
   input wire logic o_mon_wake,
   input wire logic o_mon_aux,
   input wire logic [NPINS-1:0] o_short_flags,
   input wire logic o_hv_irq
);
   localparam int HI = int'(P_WAKE_TIMEOUT_CYC) + 3;
   logic calm;
   logic reen;
   // a filter event already in flight would win over the clear, so ask for quiet inputs
   assign calm = !(i_bus_short || i_aux_short || i_wake_short || i_thermal_evt);
   assign reen = i_cfg_wr && i_cfg_wdata[REENABLE_BIT];
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence reen_write;
      calm[*2] ##1 (calm && reen);
   endsequence
   sequence wake_up;
      $rose(o_wake_pin_oe) ##0 !o_cfg_rdata[WTO_DIS_BIT];
   endsequence
   a_tmon_follow: assert property (
      i_cfg_wr |=> o_tmon_en == $past(i_cfg_wdata[TMON_BIT]))
      else $error("temperature monitor enable wrong");
   a_vshort_follow: assert property (
      i_cfg_wr |=> o_vshort_en == $past(i_cfg_wdata[VSHORT_BIT]))
      else $error("voltage short enable wrong");
   a_bit3_zero: assert property (!o_cfg_rdata[REENABLE_BIT])
      else $error("re-enable bit reads one");
   a_pullup_follow: assert property (
      i_cfg_wr |=> o_wake_pullup_en == $past(i_cfg_wdata[PULLUP_BIT]))
      else $error("pull-up enable wrong");
   a_pulldown_follow: assert property (
      !$past(i_rst) |-> o_wake_pulldown_en == !$past(i_wake_assert))
      else $error("pull-down enable wrong");
   a_irq_gated: assert property (!i_irq_en |=> !o_hv_irq)
      else $error("interrupt while disabled");
   a_mon_gated: assert property (
      !o_cfg_rdata[READBACK_BIT] [*2] |-> !(o_mon_wake || o_mon_aux))
      else $error("readback without enable");
   a_reenable_all: assert property (
      reen_write |=> o_bus_drv_en && o_aux_drv_en && o_wake_drv_en && o_short_flags == 3'h0)
      else $error("re-enable write did not restore");
   a_passive_keep: assert property (
      o_cfg_rdata[PASSIVE_BIT] && !i_cfg_wr && o_bus_drv_en |=> o_bus_drv_en)
      else $error("passive mode cut the bus driver");
   a_active_cut: assert property (
      $rose(o_short_flags[PIN_BUS]) && !o_cfg_rdata[PASSIVE_BIT] |-> !o_bus_drv_en)
      else $error("active mode kept the bus driver");
   a_flag_sticky: assert property (
      o_short_flags[PIN_BUS] && !reen |=> o_short_flags[PIN_BUS])
      else $error("short flag cleared without write");
   a_cut_holds: assert property (!o_bus_drv_en && !reen |=> !o_bus_drv_en)
      else $error("bus driver restored without write");
   // a thermal or wake short event may still cut the driver legally
   a_timeout_off: assert property (
      o_cfg_rdata[WTO_DIS_BIT] && o_wake_pin_oe && i_wake_assert && !i_cfg_wr && calm
         && !$past(i_wake_short) |=> o_wake_pin_oe)
      else $error("wake dropped with timeout disabled");
   a_wake_drop: assert property (wake_up |-> ##[1:HI] !o_wake_pin_oe)
      else $error("wake timeout missed");
endmodule
`default_nettype wire

// ### tb/test_hv_pin_config_control.sv
// self-checking bench for the configuration control block
`timescale 1ns/10ps
`default_nettype none
module test_hv_pin_config_control;
   import hv_cfg_pkg::*;
   localparam int TO = 20;
   typedef struct packed {logic [7:0] wd; logic [7:0] rd; logic [2:0] an;} row_t;
   logic i_clk = 0, i_rst = 1, i_cfg_wr = 0, i_status_rd = 0, i_wake_assert = 0, i_irq_en = 1;
   logic i_bus_short = 0, i_aux_short = 0, i_wake_short = 0, i_thermal_evt = 0;
   logic i_wake_pin = 0, i_aux_pin = 0;
   logic [CFG_W-1:0] i_cfg_wdata = 8'h00;
   logic [CFG_W-1:0] o_cfg_rdata;
   logic o_wake_pin, o_wake_pin_oe, o_tmon_en, o_vshort_en, o_wake_pullup_en, o_wake_pulldown_en;
   logic o_bus_drv_en, o_aux_drv_en, o_wake_drv_en, o_mon_wake, o_mon_aux, o_hv_irq;
   logic [NPINS-1:0] o_short_flags;
   logic [1:0] o_edge_flags;
   logic [2:0] drv;
   int errors = 0, check_count = 0, cycles = 0;
   row_t rows [4] = '{'{8'h58, 8'h50, 3'h4}, '{8'h20, 8'h20, 3'h2}, '{8'h81, 8'h81, 3'h1},
      '{8'h7f, 8'h77, 3'h7}};
   assign drv = {o_wake_drv_en, o_aux_drv_en, o_bus_drv_en};
   hv_pin_config_control #(.P_WAKE_SHORT_CYC(8), .P_WAKE_TIMEOUT_CYC(TO)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata),
      .o_cfg_rdata(o_cfg_rdata), .i_status_rd(i_status_rd), .i_wake_assert(i_wake_assert),
      .i_irq_en(i_irq_en), .i_bus_short(i_bus_short), .i_aux_short(i_aux_short),
      .i_wake_short(i_wake_short), .i_thermal_evt(i_thermal_evt), .i_wake_pin(i_wake_pin),
      .o_wake_pin(o_wake_pin), .o_wake_pin_oe(o_wake_pin_oe), .i_aux_pin(i_aux_pin),
      .o_tmon_en(o_tmon_en), .o_vshort_en(o_vshort_en), .o_wake_pullup_en(o_wake_pullup_en),
      .o_wake_pulldown_en(o_wake_pulldown_en), .o_bus_drv_en(o_bus_drv_en),
      .o_aux_drv_en(o_aux_drv_en), .o_wake_drv_en(o_wake_drv_en), .o_mon_wake(o_mon_wake),
      .o_mon_aux(o_mon_aux), .o_short_flags(o_short_flags), .o_edge_flags(o_edge_flags),
      .o_hv_irq(o_hv_irq));
   task automatic tally_and_finish();
      if (errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // one ns past the edge so every check sees settled registers
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] d);
      i_cfg_wr <= 1'b1;
      i_cfg_wdata <= d;
      tick(1);
      i_cfg_wr <= 1'b0;
      tick(1);
   endtask
   task automatic stat();
      i_status_rd <= 1'b1;
      tick(1);
      i_status_rd <= 1'b0;
      tick(1);
   endtask
   initial begin
      forever #4 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end
   initial begin
      tick(5);
      i_rst <= 1'b0;
      tick(1);
      chk(o_cfg_rdata, 8'h00);
      chk(8'(drv), 8'h07);
      chk({o_wake_pulldown_en, o_wake_pin_oe, o_short_flags, o_edge_flags, o_hv_irq}, 8'h80);
      foreach (rows[k]) begin
         wr(rows[k].wd);
         chk(o_cfg_rdata, rows[k].rd);
         chk(8'({o_tmon_en, o_vshort_en, o_wake_pullup_en}), 8'(rows[k].an));
      end
      wr(8'h00);
      i_wake_pin <= 1'b1;
      i_aux_pin <= 1'b1;
      tick(8);
      chk(8'({o_mon_wake, o_mon_aux, o_edge_flags}), 8'h00);
      wr(8'h10);
      tick(8);
      stat();
      chk(8'({o_mon_wake, o_mon_aux, o_edge_flags}), 8'h0c);
      i_wake_pin <= 1'b0;
      tick(6);
      chk(8'({o_mon_wake, o_edge_flags, o_hv_irq}), 8'h03);
      stat();
      tick(4);
      chk(8'({o_edge_flags, o_hv_irq}), 8'h00);
      i_aux_pin <= 1'b0;
      i_irq_en <= 1'b0;
      tick(6);
      chk(8'({o_mon_aux, o_edge_flags, o_hv_irq}), 8'h04);
      stat();
      i_irq_en <= 1'b1;
      wr(8'h04);
      i_bus_short <= 1'b1;
      tick(2600);
      i_bus_short <= 1'b0;
      tick(3);
      chk(8'({drv, o_short_flags, o_hv_irq}), 8'h73);
      wr(8'h0c);
      chk(8'({drv, o_short_flags}), 8'h38);
      // one sample short of the limit must leave no trace
      i_bus_short <= 1'b1;
      tick(2499);
      i_bus_short <= 1'b0;
      tick(4);
      chk(8'({o_short_flags, o_hv_irq}), 8'h00);
      wr(8'h00);
      i_bus_short <= 1'b1;
      i_aux_short <= 1'b1;
      tick(2600);
      i_bus_short <= 1'b0;
      i_aux_short <= 1'b0;
      tick(20);
      chk(8'({drv, o_short_flags}), 8'h23);
      i_wake_short <= 1'b1;
      tick(12);
      i_wake_short <= 1'b0;
      tick(3);
      chk(8'({drv, o_short_flags}), 8'h07);
      wr(8'h08);
      chk(8'({drv, o_short_flags}), 8'h38);
      i_thermal_evt <= 1'b1;
      tick(1);
      i_thermal_evt <= 1'b0;
      tick(10);
      chk(8'(drv), 8'h01);
      wr(8'h08);
      chk(8'(drv), 8'h07);
      i_wake_assert <= 1'b1;
      tick(2);
      chk(8'({o_wake_pin, o_wake_pin_oe, o_wake_pulldown_en}), 8'h06);
      tick(TO - 4);
      chk(8'(o_wake_pin_oe), 8'h01);
      tick(8);
      chk(8'({o_wake_pin, o_wake_pin_oe}), 8'h00);
      wr(8'h02);
      i_wake_assert <= 1'b0;
      tick(2);
      i_wake_assert <= 1'b1;
      tick(TO + 10);
      chk(8'(o_wake_pin_oe), 8'h01);
      // mid-run reset, then a write on the first edge after release
      i_rst <= 1'b1;
      i_wake_assert <= 1'b0;
      tick(1);
      chk(o_cfg_rdata, 8'h00);
      chk(8'({drv, o_wake_pin_oe, o_wake_pulldown_en}), 8'h1d);
      i_rst <= 1'b0;
      wr(8'h10);
      chk(o_cfg_rdata, 8'h10);
      // an edge landing together with the status read must survive it
      i_wake_pin <= 1'b1;
      tick(3);
      i_status_rd <= 1'b1;
      tick(1);
      i_status_rd <= 1'b0;
      chk(8'({o_edge_flags, o_hv_irq}), 8'h03);
      tally_and_finish();
   end
endmodule
bind hv_pin_config_control hv_pin_config_control_monitor #(
   .P_WAKE_TIMEOUT_CYC(P_WAKE_TIMEOUT_CYC)) mon (
   .i_clk(i_clk), .i_rst(i_rst), .i_cfg_wr(i_cfg_wr), .i_cfg_wdata(i_cfg_wdata),
   .i_wake_assert(i_wake_assert), .i_irq_en(i_irq_en), .i_bus_short(i_bus_short),
   .i_aux_short(i_aux_short), .i_wake_short(i_wake_short), .i_thermal_evt(i_thermal_evt),
   .o_cfg_rdata(o_cfg_rdata), .o_tmon_en(o_tmon_en), .o_vshort_en(o_vshort_en),
   .o_wake_pullup_en(o_wake_pullup_en), .o_wake_pulldown_en(o_wake_pulldown_en),
   .o_bus_drv_en(o_bus_drv_en), .o_aux_drv_en(o_aux_drv_en), .o_wake_drv_en(o_wake_drv_en),
   .o_wake_pin_oe(o_wake_pin_oe), .o_mon_wake(o_mon_wake), .o_mon_aux(o_mon_aux),
   .o_short_flags(o_short_flags), .o_hv_irq(o_hv_irq));
`default_nettype wire
